//--- design/dca_pkg.sv
package dca_pkg;
    // Register byte addresses (printed offsets not all multiples of four: index * 4)
    localparam logic [7:0] DEV_CFG_TWO_IDX = 8'h15;
    localparam logic [7:0] AUX_PIN_CFG_IDX = 8'h16;
    localparam logic [7:0] PIN_LEVEL_IDX = 8'h17;
    localparam logic [7:0] SIDEBAND_IDX = 8'h20;
    localparam logic [9:0] DEV_CFG_TWO_ADDR = {DEV_CFG_TWO_IDX, 2'b00};
    localparam logic [9:0] AUX_PIN_CFG_ADDR = {AUX_PIN_CFG_IDX, 2'b00};
    localparam logic [9:0] PIN_LEVEL_ADDR = {PIN_LEVEL_IDX, 2'b00};
    localparam logic [9:0] SIDEBAND_ADDR = {SIDEBAND_IDX, 2'b00};
    // Device config two fields
    localparam int RSV_LSB = 8;
    localparam int RSV_W = 4;
    localparam int CP_OFF_BIT = 6;
    localparam int FORCE_RST_BIT = 5;
    localparam int DC_TEST_BIT = 4;
    localparam int SER_TO_OFF_BIT = 2;
    localparam int ACQ_WD_OFF_BIT = 1;
    localparam int BAL_WD_OFF_BIT = 0;
    localparam logic [15:0] DEV_CFG_TWO_RESET = 16'h4000;
    localparam logic [15:0] DEV_CFG_TWO_MASK = 16'hEF77;
    // Aux pin config fields
    localparam int TWI_ON_BIT = 15;
    localparam int PIN_MODE_LSB = 8;
    localparam int PIN_DIR_LSB = 0;
    localparam logic [15:0] AUX_PIN_CFG_RESET = 16'h0F00;
    localparam logic [15:0] AUX_PIN_CFG_MASK = 16'h8F0F;
    // Sideband register: user alert control in bit 0
    localparam int USER_ALERT_BIT = 0;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

//--- design/dca_cfg_bank.sv
`timescale 1ns/1ps
// Function
// R01: Reserved field bits 11:8 of config two store and return software's value.
// R02: Charge-pump off bit disables the high-voltage charge pump; clear keeps it running.
// R03: Force-reset bit enables internal pull-down on shutdown pin; defaults zero.
// R04: Clearing force-reset before the reset happens releases the pull-down.
// R05: Host should stop link traffic while a forced reset is pending.
// R06: DC test on with host link selected drives alert pin low on alert.
// R07: In DC test mode the user alert control forces the alert pin level.
// R08: DC test mode works in every link port setup, differential included.
// R09: With serial interface selected, DC test bit does not affect the pin.
// R10: Serial timeout off bit stops serial monitor; ignored when host link selected.
// R11: Acquisition watchdog off stops watchdog; leaves timeout flag untouched.
// R12: Balancing watchdog off stops watchdog; leaves balancing flag untouched.
// R13: Two-wire on makes pin 0 open-drain data, pin 1 open-drain clock.
// R14: In two-wire mode other selections for pins 1 and 0 are ignored.
// R15: Pin 1 and 0 mode bits still read back written values in two-wire mode.
// R16: Pin mode bit: zero analog high-Z, one digital; field resets to all ones.
// R17: Direction bit: zero input, one output; applies only in digital mode.
// R18: A digital input pin enables its internal pull-down.
// R19: A digital output pin keeps its input path active.
// R20: Digital pins report sampled input level; non-digital pins read zero.
module dca_cfg_bank
    import dca_pkg::*;
#(
    parameter int PINS = 4
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // AXI4-Lite write address
    input wire logic [9:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [9:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Device context
    input wire logic host_link_select,
    input wire logic alert_present,
    input wire logic por_done,
    // Analog and watchdog controls
    output logic charge_pump_off,
    output logic shutdown_n_pin_pulldown,
    output logic serial_timeout_off,
    output logic acquisition_watchdog_off,
    output logic balancing_watchdog_off,
    // Alert pin override
    output logic alert_output_pin_o,
    output logic alert_output_pin_oe,
    // Aux pins
    input wire logic [PINS-1:0] aux_pin_i,
    output logic [PINS-1:0] aux_pin_o,
    output logic [PINS-1:0] aux_pin_oe,
    output logic [PINS-1:0] aux_pin_pulldown,
    output logic [PINS-1:0] aux_pin_input_on,
    output logic two_wire_master_on,
    // Two-wire master side
    input wire logic twi_data_drive_low,
    input wire logic twi_clock_drive_low,
    output logic twi_data_in,
    // GPIO output state from data register
    input wire logic [PINS-1:0] pin_drive_level
);

    // Field layout must leave room for every pin
    if (PINS != 4) begin : g_pins_chk
        $error("dca_cfg_bank supports exactly four aux pins");
    end
    if (PIN_DIR_LSB + PINS > PIN_MODE_LSB) begin : g_dir_chk
        $error("direction field overlaps pin mode field");
    end
    if (PIN_MODE_LSB + PINS > TWI_ON_BIT) begin : g_mode_chk
        $error("pin mode field overlaps two-wire enable");
    end

    logic [15:0] dev_cfg_two;
    logic [15:0] aux_pin_config;
    logic user_alert_control;
    logic [PINS-1:0] pin_sync1;
    logic [PINS-1:0] pin_sync2;
    logic [PINS-1:0] pin_input_level;
    logic [9:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic have_aw;
    logic have_w;
    logic do_write;
    logic [15:0] next_dev_cfg_two;
    logic [15:0] next_aux_pin_config;
    logic [15:0] wr_mask;
    logic wr_hit;
    logic [31:0] rd_word;
    logic rd_hit;

    // Write channel: address and data accepted in either order
    // A pending response blocks the next write, one write at a time
    assign do_write = have_aw && have_w && !s_axi_bvalid;
    assign wr_mask = {{8{wr_strb[1]}}, {8{wr_strb[0]}}};

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            have_aw <= 1'b0;
            wr_addr <= 10'h000;
        end else if (s_axi_awvalid && s_axi_awready) begin
            have_aw <= 1'b1;
            wr_addr <= s_axi_awaddr;
        end else if (do_write) begin
            have_aw <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            have_w <= 1'b0;
            wr_data <= 32'h0000_0000;
            wr_strb <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            have_w <= 1'b1;
            wr_data <= s_axi_wdata;
            wr_strb <= s_axi_wstrb;
        end else if (do_write) begin
            have_w <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_awready <= !have_aw && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready <= !have_w && !(s_axi_wvalid && s_axi_wready);
        end
    end

    always_comb begin
        wr_hit = 1'b1;
        next_dev_cfg_two = dev_cfg_two;
        next_aux_pin_config = aux_pin_config;
        unique case (wr_addr)
            DEV_CFG_TWO_ADDR: begin
                // Reserved field stored as written [R01]
                next_dev_cfg_two = (dev_cfg_two & ~wr_mask)
                    | (wr_data[15:0] & wr_mask & DEV_CFG_TWO_MASK);
            end
            AUX_PIN_CFG_ADDR: begin
                // Pin 1:0 bits kept even in two-wire mode for readback [R15]
                next_aux_pin_config = (aux_pin_config & ~wr_mask)
                    | (wr_data[15:0] & wr_mask & AUX_PIN_CFG_MASK);
            end
            SIDEBAND_ADDR, PIN_LEVEL_ADDR: begin
                wr_hit = (wr_addr == SIDEBAND_ADDR);
            end
            default: begin
                wr_hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            dev_cfg_two <= DEV_CFG_TWO_RESET;
        end else if (do_write) begin
            dev_cfg_two <= next_dev_cfg_two;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            aux_pin_config <= AUX_PIN_CFG_RESET; // [R16]
        end else if (do_write) begin
            aux_pin_config <= next_aux_pin_config;
        end
    end

    // Sideband word holds the user alert control, kept outside both registers
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            user_alert_control <= 1'b0;
        end else if (do_write && wr_addr == SIDEBAND_ADDR && wr_strb[0]) begin
            user_alert_control <= wr_data[USER_ALERT_BIT]; // [R07]
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (do_write) begin
            // Unmapped or read-only offsets answer with an error and change nothing
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Read channel
    // Address decoded while arvalid stands, so no capture register is needed
    always_comb begin
        rd_hit = 1'b1;
        rd_word = 32'h0000_0000;
        unique case (s_axi_araddr)
            DEV_CFG_TWO_ADDR: rd_word[15:0] = dev_cfg_two; // [R01]
            AUX_PIN_CFG_ADDR: rd_word[15:0] = aux_pin_config;
            PIN_LEVEL_ADDR: rd_word[PINS-1:0] = pin_input_level;
            SIDEBAND_ADDR: rd_word[USER_ALERT_BIT] = user_alert_control;
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid) begin
            if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end else begin
            s_axi_arready <= 1'b1;
        end
    end

    // Control outputs
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            charge_pump_off <= 1'b0;
            serial_timeout_off <= 1'b0;
            acquisition_watchdog_off <= 1'b0;
            balancing_watchdog_off <= 1'b0;
            shutdown_n_pin_pulldown <= 1'b0;
        end else begin
            charge_pump_off <= dev_cfg_two[CP_OFF_BIT]; // [R02]
            // Host link selected masks the serial monitor control [R10]
            serial_timeout_off <= dev_cfg_two[SER_TO_OFF_BIT] && !host_link_select;
            // Watchdog stop only; their flags live elsewhere and are never cleared here
            acquisition_watchdog_off <= dev_cfg_two[ACQ_WD_OFF_BIT]; // [R11]
            balancing_watchdog_off <= dev_cfg_two[BAL_WD_OFF_BIT]; // [R12]
            // Follows the bit, so clearing it before reset lands drops the pull-down
            shutdown_n_pin_pulldown <= dev_cfg_two[FORCE_RST_BIT] && !por_done; // [R03] [R04]
        end
    end

    // Alert DC test: independent of link port setup, so every setup is covered [R08]
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            alert_output_pin_o <= 1'b1;
            alert_output_pin_oe <= 1'b0;
        end else if (dev_cfg_two[DC_TEST_BIT] && host_link_select) begin
            alert_output_pin_oe <= 1'b1;
            alert_output_pin_o <= !(alert_present || user_alert_control); // [R06] [R07]
        end else begin
            // Serial mode or DC test off: pin left to its normal owner [R09]
            alert_output_pin_oe <= 1'b0;
            alert_output_pin_o <= 1'b1;
        end
    end

    // Pin input synchronisers
    // Two flops: pins are asynchronous to the oscillator
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_sync1 <= '0;
            pin_sync2 <= '0;
        end else begin
            pin_sync1 <= aux_pin_i;
            pin_sync2 <= pin_sync1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            two_wire_master_on <= 1'b0;
            twi_data_in <= 1'b1;
        end else begin
            two_wire_master_on <= aux_pin_config[TWI_ON_BIT]; // [R13]
            twi_data_in <= pin_sync2[0];
        end
    end

    genvar g;
    generate
        for (g = 0; g < PINS; g++) begin : g_pin
            logic digital;
            logic outdir;
            logic twi_pin;
            assign twi_pin = aux_pin_config[TWI_ON_BIT] && (g < 2);
            // Two-wire mode overrides pin config for pins 1:0 [R14]
            assign digital = aux_pin_config[PIN_MODE_LSB + g] && !twi_pin; // [R16]
            assign outdir = digital && aux_pin_config[PIN_DIR_LSB + g]; // [R17]

            always_ff @(posedge ref_clk or negedge rst_n) begin
                if (!rst_n) begin
                    aux_pin_o[g] <= 1'b0;
                    aux_pin_oe[g] <= 1'b0;
                    aux_pin_pulldown[g] <= 1'b0;
                    aux_pin_input_on[g] <= 1'b0;
                    pin_input_level[g] <= 1'b0;
                end else begin
                    if (twi_pin) begin
                        // Open-drain: drive low only [R13]
                        aux_pin_o[g] <= 1'b0;
                        aux_pin_oe[g] <= (g == 0) ? twi_data_drive_low
                                                  : twi_clock_drive_low;
                    end else begin
                        aux_pin_o[g] <= pin_drive_level[g];
                        aux_pin_oe[g] <= outdir; // [R17]
                    end
                    aux_pin_pulldown[g] <= digital && !outdir; // [R18]
                    // Input path stays on for outputs too [R19]
                    aux_pin_input_on[g] <= digital || twi_pin;
                    pin_input_level[g] <= digital && pin_sync2[g]; // [R20]
                end
            end
        end
    endgenerate

endmodule

//--- test/dca_cfg_bank_asserts.sv
`timescale 1ns/1ps
module dca_chk
    import dca_pkg::*;
#(
    parameter int PINS = 4
) (
    // Clock, reset, bus
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic s_axi_bvalid,
    // Context
    input wire logic host_link_select,
    input wire logic alert_present,
    input wire logic por_done,
    input wire logic twi_data_drive_low,
    input wire logic twi_clock_drive_low,
    // Controls
    input wire logic charge_pump_off,
    input wire logic shutdown_n_pin_pulldown,
    input wire logic serial_timeout_off,
    input wire logic acquisition_watchdog_off,
    input wire logic balancing_watchdog_off,
    input wire logic alert_output_pin_o,
    input wire logic alert_output_pin_oe,
    // Pins
    input wire logic [PINS-1:0] aux_pin_o,
    input wire logic [PINS-1:0] aux_pin_oe,
    input wire logic [PINS-1:0] aux_pin_pulldown,
    input wire logic [PINS-1:0] aux_pin_input_on,
    input wire logic two_wire_master_on
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    sequence ctl_changed;
        $changed({charge_pump_off, acquisition_watchdog_off, balancing_watchdog_off});
    endsequence
    // Either edge of the response counts: output lag is one edge at most
    ctl_follow_write_a: assert property (
        ctl_changed |-> s_axi_bvalid || $past(s_axi_bvalid))
        else $error("control moved without a write");
    pd_rise_a: assert property ($rose(shutdown_n_pin_pulldown) |-> !$past(por_done))
        else $error("pull-down rose after reset event");
    pd_release_a: assert property (por_done |=> !shutdown_n_pin_pulldown)
        else $error("pull-down held after reset event");
    alert_spi_a: assert property (!host_link_select |=> !alert_output_pin_oe)
        else $error("alert pin driven in serial mode");
    alert_level_a: assert property (
        alert_output_pin_oe && $past(alert_present) |-> !alert_output_pin_o)
        else $error("alert pin high during alert");
    sto_ignored_a: assert property (host_link_select |=> !serial_timeout_off)
        else $error("serial timeout off with link selected");
    pin_path_a: assert property (
        ((aux_pin_pulldown | aux_pin_oe) & ~aux_pin_input_on) == '0
        && (aux_pin_pulldown & aux_pin_oe) == '0)
        else $error("pin pull-down or input path wrong");
    twi_pins_a: assert property (
        two_wire_master_on |-> aux_pin_o[1:0] == 2'b00 && aux_pin_pulldown[1:0] == 2'b00
        && aux_pin_oe[1:0] == $past({twi_clock_drive_low, twi_data_drive_low}))
        else $error("two-wire pins wrong");
endmodule

bind dca_cfg_bank dca_chk #(.PINS(PINS)) dca_chk_inst (.ref_clk, .rst_n, .s_axi_bvalid,
    .host_link_select, .alert_present, .por_done, .twi_data_drive_low, .twi_clock_drive_low,
    .charge_pump_off, .shutdown_n_pin_pulldown, .serial_timeout_off, .acquisition_watchdog_off,
    .balancing_watchdog_off, .alert_output_pin_o, .alert_output_pin_oe, .aux_pin_o, .aux_pin_oe,
    .aux_pin_pulldown, .aux_pin_input_on, .two_wire_master_on);

//--- test/device_cfg_and_aux_pin_cfg_bench.sv
`timescale 1ns/1ps
module device_cfg_and_aux_pin_cfg_bench
    import dca_pkg::*;
;
    logic ref_clk, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [9:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb, aux_pin_i, aux_pin_o, aux_pin_oe, aux_pin_pulldown;
    logic [3:0] aux_pin_input_on, pin_drive_level;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic host_link_select, alert_present, por_done, twi_data_drive_low, twi_clock_drive_low;
    logic charge_pump_off, shutdown_n_pin_pulldown, serial_timeout_off, twi_data_in;
    logic acquisition_watchdog_off, balancing_watchdog_off, alert_output_pin_o;
    logic alert_output_pin_oe, two_wire_master_on;
    int n_mismatch = 0;
    int tests_run = 0;
    dca_cfg_bank #(.PINS(4)) dca_cfg_bank_inst (.ref_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .host_link_select, .alert_present, .por_done,
        .charge_pump_off, .shutdown_n_pin_pulldown, .serial_timeout_off, .acquisition_watchdog_off,
        .balancing_watchdog_off, .alert_output_pin_o, .alert_output_pin_oe, .aux_pin_i, .aux_pin_o,
        .aux_pin_oe, .aux_pin_pulldown, .aux_pin_input_on, .two_wire_master_on,
        .twi_data_drive_low, .twi_clock_drive_low, .twi_data_in, .pin_drive_level);
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    task automatic complete_run;
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wait_cy(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic wr(input logic [9:0] a, input logic [31:0] v);
        logic aw, w;
        aw = 1'b1;
        w = 1'b1;
        @(posedge ref_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (aw || w) begin
            @(posedge ref_clk);
            aw = aw && !s_axi_awready;
            w = w && !s_axi_wready;
            s_axi_awvalid <= aw;
            s_axi_wvalid <= w;
        end
        do @(posedge ref_clk); while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [9:0] a);
        @(posedge ref_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge ref_clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge ref_clk); while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic t_reset;
        rd(DEV_CFG_TWO_ADDR);
        chk("dev_cfg_two", d, {16'h0, DEV_CFG_TWO_RESET});
        rd(AUX_PIN_CFG_ADDR);
        chk("aux_pin_config", d, {16'h0, AUX_PIN_CFG_RESET});
        chk("pulldown", 32'(aux_pin_pulldown), 32'hF);
        chk("pin_oe", 32'(aux_pin_oe), 32'h0);
    endtask
    task automatic t_devcfg;
        wr(DEV_CFG_TWO_ADDR, 32'h0000_FFFF);
        rd(DEV_CFG_TWO_ADDR);
        chk("dev_cfg_two", d, 32'(DEV_CFG_TWO_MASK));
        chk("ctl", 32'({charge_pump_off, shutdown_n_pin_pulldown, serial_timeout_off,
            acquisition_watchdog_off, balancing_watchdog_off}),
            32'h1F);
        host_link_select <= 1'b1;
        por_done <= 1'b1;
        // Bus kept quiet while the forced reset is pending
        wait_cy(2);
        chk("serial_to", 32'(serial_timeout_off), 32'h0);
        chk("pulldown_por", 32'(shutdown_n_pin_pulldown), 32'h0);
        @(posedge ref_clk);
        por_done <= 1'b0;
        // Clearing the reset request must drop the pull-down, nothing else
        wr(DEV_CFG_TWO_ADDR, 32'h0000_0F57);
        wait_cy(2);
        chk("ctl_clear", 32'({charge_pump_off, shutdown_n_pin_pulldown, serial_timeout_off,
            acquisition_watchdog_off, balancing_watchdog_off}), 32'h13);
    endtask
    task automatic t_alert;
        chk("alert_oe", 32'({alert_output_pin_oe, alert_output_pin_o}), 32'h3);
        @(posedge ref_clk);
        alert_present <= 1'b1;
        wait_cy(2);
        chk("alert_o", 32'(alert_output_pin_o), 32'h0);
        alert_present <= 1'b0;
        wr(SIDEBAND_ADDR, 32'h1);
        wait_cy(2);
        chk("alert_user", 32'(alert_output_pin_o), 32'h0);
        wr(SIDEBAND_ADDR, 32'h0);
        wait_cy(2);
        chk("alert_free", 32'(alert_output_pin_o), 32'h1);
        host_link_select <= 1'b0;
        wait_cy(2);
        chk("alert_spi", 32'(alert_output_pin_oe), 32'h0);
    endtask
    task automatic t_aux;
        aux_pin_i <= 4'hF;
        pin_drive_level <= 4'h1;
        wr(AUX_PIN_CFG_ADDR, 32'h0000_0305);
        wait_cy(4);
        chk("oe", 32'(aux_pin_oe), 32'h1);
        chk("o0", 32'(aux_pin_o[0]), 32'h1);
        chk("pd", 32'(aux_pin_pulldown), 32'h2);
        chk("in_on", 32'(aux_pin_input_on), 32'h3);
        rd(PIN_LEVEL_ADDR);
        chk("level", d, 32'h3);
    endtask
    task automatic t_twi;
        twi_data_drive_low <= 1'b1;
        twi_clock_drive_low <= 1'b1;
        aux_pin_i <= 4'hE;
        // Pins 1:0 asked to be outputs, which two-wire mode must override
        wr(AUX_PIN_CFG_ADDR, 32'h0000_8F03);
        wait_cy(4);
        chk("twm", 32'(two_wire_master_on), 32'h1);
        chk("twi_oe", 32'({aux_pin_oe, aux_pin_o[1:0]}), 32'hC);
        chk("twi_pd", 32'(aux_pin_pulldown), 32'hC);
        chk("twi_in", 32'(twi_data_in), 32'h0);
        rd(AUX_PIN_CFG_ADDR);
        chk("aux_rb", d, 32'h8F03);
    endtask
    task automatic t_err;
        rd(10'h3FC);
        chk("unmapped_rd", 32'(r), 32'(RESP_SLVERR));
        wr(PIN_LEVEL_ADDR, 32'h0);
        chk("ro_wr", 32'(r), 32'(RESP_SLVERR));
    endtask
    initial begin
        {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hF;
        {host_link_select, alert_present, por_done, twi_data_drive_low, twi_clock_drive_low} = '0;
        aux_pin_i = 4'h0;
        pin_drive_level = 4'h0;
        repeat (16) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_reset;
        t_devcfg;
        t_alert;
        t_aux;
        t_twi;
        t_err;
        complete_run;
    end
    // Whole sequence needs well under a thousand cycles
    initial begin
        #20000;
        n_mismatch++;
        complete_run;
    end
endmodule
